/* File: irq_idle_pkg.sv */
// constants for the interrupt and idle control block
// Function
// - eleven sources plus reset, fixed priority
// - reset vector 0000, timer 0028, powerdown 002c
// - four dedicated plus two alternate external inputs
// - configurable inputs choose edge or level
// - control register sets nesting and sensitivity
// - mask gates requests, highest unmasked wins
// - powerdown and reset are not maskable
// - mask write blocks interrupts one cycle
// - force/clear register sets or clears pending
// - status stack pushed and popped, twelve deep
// - global enable gates all, powerdown included
// - idle waits for unmasked interrupt, then resumes
// - cycle steals still granted while idle
// - slow idle divides clock by 16..128
// - slow idle wake takes up to divisor cycles
// - idle without divisor wakes in one cycle
// - powerdown by pin or force bit, edge, nonmaskable
// - powerdown exit after 400 or 4096 clocks
// - reset ends powerdown
// - acknowledge output shows powerdown entered
// - context bit picks resume or clean restart
// - reset empties stack, masks all, clears status
package irq_idle_pkg;
  localparam int NUM_SRC = 11;
  localparam int STACK_DEPTH = 12;
  localparam int CLK_MHZ = 100;
  localparam int WAKE_FAST_INPUT_CLOCK_PIN = 400;
  localparam int WAKE_XTAL_INPUT_CLOCK_PIN = 4096;
  localparam int WAKE_FAST_CYC = WAKE_FAST_INPUT_CLOCK_PIN;
  localparam int WAKE_XTAL_CYC = WAKE_XTAL_INPUT_CLOCK_PIN;
  // source index = priority order, 0 highest among maskables
  localparam int SRC_CFG = 0;
  localparam int SRC_LVL_B = 1;
  localparam int SRC_LVL_A = 2;
  localparam int SRC_SA_TX = 3;
  localparam int SRC_SA_RX = 4;
  localparam int SRC_EDGE = 5;
  localparam int SRC_BYTE_DMA_PORT = 6;
  localparam int SRC_SB_TX = 7;
  localparam int SRC_SB_RX = 8;
  localparam int SRC_TIMER = 9;
  localparam int SRC_SOFT = 10;
  localparam logic [13:0] VEC_RESET = 14'h0000;
  localparam logic [13:0] VEC_PWDN = 14'h002c;
  localparam logic [13:0] VEC_BASE = 14'h0004;
  localparam logic [10:0] MASK_RESET = 11'h000;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
endpackage : irq_idle_pkg

/* File: irq_idle_ctrl.sv */
// interrupt arbitration, idle and power-down control
`timescale 1ns/10ps
module irq_idle_ctrl #(
  parameter int WAKE_XTAL = irq_idle_pkg::WAKE_XTAL_CYC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ext_int_configurable_n,
  input wire logic ext_level_int_a_n,
  input wire logic ext_level_int_b_n,
  input wire logic ext_edge_int_n,
  input wire logic serial_b_alt_rx_int_n,
  input wire logic serial_b_alt_tx_int_n,
  input wire logic serial_b_alt_mode,
  input wire logic [10:0] periph_req,
  input wire logic powerdown_request_pin_n,
  input wire logic mask_wr,
  input wire logic [10:0] mask_wdata,
  input wire logic ctrl_wr,
  input wire logic [3:0] ctrl_wdata,
  input wire logic fc_wr,
  input wire logic [11:0] fc_force,
  input wire logic [11:0] fc_clear,
  input wire logic global_int_enable_instr,
  input wire logic global_int_disable_instr,
  input wire logic int_return,
  input wire logic [15:0] status_in,
  input wire logic idle_instr,
  input wire logic [1:0] idle_div_sel,
  input wire logic idle_div_en,
  input wire logic powerdown_enter,
  input wire logic xtal_disabled,
  input wire logic powerup_context_bit,
  input wire logic [2:0] steal_req,
  output logic [2:0] steal_grant,
  output logic int_take,
  output logic [13:0] int_vector,
  output logic [15:0] status_out,
  output logic stack_empty,
  output logic stack_overflow,
  output logic [10:0] int_mask_reg,
  output logic [10:0] pending,
  output logic core_clk_en,
  output logic idling,
  output logic powerdown_ack,
  output logic context_clear
);
  typedef enum logic [3:0] {
    ST_RUN = 4'h1, ST_IDLE = 4'h2, ST_PWDN = 4'h4, ST_WAKE = 4'h8
  } mode_e;

  // first stage only feeds the second stage
  logic [6:0] meta_q, sync_q, sync_prev_q;
  logic [10:0] mask_q, edge_pend_q, lvl_now;
  logic [3:0] ctrl_q;
  logic gie_q, blk_q, pwd_pend_q;
  logic [11:0] active_q;
  localparam int STACK_DEPTH_L = irq_idle_pkg::STACK_DEPTH;
  logic [15:0] stk_q [STACK_DEPTH_L];
  logic [3:0] sp_q;
  mode_e mode_q, mode_d;
  logic [7:0] div_q, divcnt_q;
  logic [12:0] wcnt_q;
  logic [13:0] vec_q;
  logic ctx_q;

  // the wake counter is 13 bits wide
  if (WAKE_XTAL < 1 || WAKE_XTAL > 8191) begin : g_bad_wake
    $error("WAKE_XTAL out of range");
  end

  always_ff @(posedge ref_clk) begin
    meta_q <= {powerdown_request_pin_n, serial_b_alt_tx_int_n,
      serial_b_alt_rx_int_n, ext_edge_int_n, ext_level_int_a_n,
      ext_level_int_b_n, ext_int_configurable_n};
    sync_q <= meta_q;
    sync_prev_q <= sync_q;
  end

  // inputs are active low; falling edge means request
  wire [6:0] fall = sync_prev_q & ~sync_q;
  wire [6:0] low = ~sync_q;
  // ctrl: 0 cfg edge, 1 alt rx edge, 2 alt tx edge, 3 nesting
  localparam int SRC_SB_RX_L = irq_idle_pkg::SRC_SB_RX;
  localparam int SRC_SB_TX_L = irq_idle_pkg::SRC_SB_TX;
  wire sb_rx_lvl = serial_b_alt_mode ? low[4] : periph_req[SRC_SB_RX_L];
  wire sb_tx_lvl = serial_b_alt_mode ? low[5] : periph_req[SRC_SB_TX_L];

  // edge capable sources: their hardware event this cycle
  wire [10:0] edge_evt = {periph_req[10:9] & 2'h3,
    serial_b_alt_mode ? fall[4] & ctrl_q[1] : periph_req[8],
    serial_b_alt_mode ? fall[5] & ctrl_q[2] : periph_req[7],
    periph_req[6], fall[3], periph_req[4:3],
    1'b0, 1'b0, fall[0] & ctrl_q[0]};
  wire [10:0] lvl_mask = {2'h0,
    serial_b_alt_mode & ~ctrl_q[1], serial_b_alt_mode & ~ctrl_q[2],
    4'h0, 2'h3, ~ctrl_q[0]};
  assign lvl_now = {2'h0, sb_rx_lvl, sb_tx_lvl, 4'h0, low[2], low[1],
    low[0]} & lvl_mask;
  wire [10:0] edge_evt_fix = {edge_evt[10:9], edge_evt[8], edge_evt[7],
    edge_evt[6:0]} & ~lvl_mask;

  wire [10:0] req = (edge_pend_q | lvl_now) & mask_q;
  wire [11:0] prio_req = {req, pwd_pend_q}; // bit 0 powerdown, nonmaskable
  function automatic logic [3:0] first_set(input logic [11:0] v);
    first_set = 4'hf;
    for (int i = 11; i >= 0; i--) if (v[i]) first_set = 4'(i);
  endfunction : first_set
  wire [3:0] win = first_set(prio_req);
  // nesting only preempts strictly higher priority than anything active
  wire [3:0] act_top = first_set(active_q);
  wire allowed = ctrl_q[3] ? (win < act_top) : (active_q == 12'h000);
  wire can_take = gie_q && !blk_q && win != 4'hf && allowed &&
    (mode_q == ST_RUN || mode_q == ST_WAKE);
  wire [13:0] win_vec = (win == 4'h0) ? irq_idle_pkg::VEC_PWDN :
    14'(irq_idle_pkg::VEC_BASE + {8'h00, win - 4'h1, 2'h0});
  wire full = sp_q == 4'(STACK_DEPTH_L);
  wire div_done = (divcnt_q == 8'h00);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mask_q <= irq_idle_pkg::MASK_RESET;
      ctrl_q <= 4'h0;
      gie_q <= 1'b1;
      blk_q <= 1'b0;
    end else begin
      if (mask_wr) mask_q <= mask_wdata;
      if (ctrl_wr) ctrl_q <= ctrl_wdata;
      blk_q <= mask_wr;
      if (global_int_disable_instr) gie_q <= 1'b0;
      else if (global_int_enable_instr) gie_q <= 1'b1;
    end
  end

  // set wins over clear for every pending flag
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      edge_pend_q <= 11'h000;
      pwd_pend_q <= 1'b0;
    end else begin
      for (int i = 0; i < 11; i++) begin
        if (edge_evt_fix[i] || (fc_wr && fc_force[i+1]))
          edge_pend_q[i] <= 1'b1;
        else if ((fc_wr && fc_clear[i+1]) ||
                 (can_take && win == 4'(i + 1)))
          edge_pend_q[i] <= 1'b0;
      end
      if (fall[6] || (fc_wr && fc_force[0]))
        pwd_pend_q <= 1'b1;
      else if ((fc_wr && fc_clear[0]) || (can_take && win == 4'h0))
        pwd_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sp_q <= 4'h0;
      active_q <= 12'h000;
      stack_overflow <= 1'b0;
    end else if (can_take) begin
      if (full) stack_overflow <= 1'b1;
      else sp_q <= sp_q + 4'h1;
      active_q[win] <= 1'b1;
    end else if (int_return && sp_q != 4'h0) begin
      sp_q <= sp_q - 4'h1;
      active_q[act_top] <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (can_take && !full) stk_q[sp_q] <= status_in;
  end

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      ST_RUN: begin
        if (powerdown_enter) mode_d = ST_PWDN;
        else if (idle_instr) mode_d = ST_IDLE;
      end
      ST_IDLE: if (win != 4'hf && gie_q && div_done) mode_d = ST_RUN;
      ST_PWDN: if (fall[6] == 1'b0 && low[6]) mode_d = ST_WAKE;
      ST_WAKE: if (wcnt_q == 13'h0000) mode_d = ST_RUN;
      default: mode_d = ST_RUN;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mode_q <= ST_RUN;
      div_q <= 8'h00;
      divcnt_q <= 8'h00;
      wcnt_q <= 13'h0000;
      ctx_q <= 1'b0;
      vec_q <= irq_idle_pkg::VEC_RESET;
      int_take <= 1'b0;
      status_out <= irq_idle_pkg::STATUS_RESET;
    end else begin
      mode_q <= mode_d;
      int_take <= can_take;
      if (can_take) vec_q <= win_vec;
      if (int_return && sp_q != 4'h0) status_out <= stk_q[sp_q - 4'h1];
      if (mode_q == ST_RUN && idle_instr) begin
        div_q <= idle_div_en ? (8'h10 << idle_div_sel) : 8'h00;
        divcnt_q <= 8'h00;
      end else if (mode_q == ST_IDLE && div_q != 8'h00)
        divcnt_q <= (divcnt_q == div_q - 8'h01) ? 8'h00 : divcnt_q + 8'h01;
      if (mode_q == ST_RUN && powerdown_enter)
        ctx_q <= powerup_context_bit;
      if (mode_q == ST_PWDN)
        wcnt_q <= xtal_disabled ? 13'(WAKE_XTAL - 1) :
          13'(irq_idle_pkg::WAKE_FAST_CYC - 1);
      else if (wcnt_q != 13'h0000)
        wcnt_q <= wcnt_q - 13'h0001;
    end
  end

  // the slow clock also gates the wake check: up to div cycles late
  assign core_clk_en = (mode_q == ST_RUN) ||
    (mode_q == ST_IDLE && div_q != 8'h00 && div_done);
  assign idling = (mode_q == ST_IDLE);
  assign steal_grant = (mode_q == ST_PWDN) ? 3'h0 : steal_req;
  assign powerdown_ack = (mode_q == ST_PWDN);
  assign context_clear = ctx_q && (mode_q == ST_WAKE);
  assign int_vector = vec_q;
  assign stack_empty = (sp_q == 4'h0);
  assign int_mask_reg = mask_q;
  assign pending = edge_pend_q | lvl_now;

  property p_mask_block;
    @(posedge ref_clk) disable iff (sys_rst) mask_wr |=> !can_take;
  endproperty
  a_mask_block: assert property (p_mask_block) else $error("take after mask write");
  property p_gie;
    @(posedge ref_clk) disable iff (sys_rst) !gie_q |=> !int_take;
  endproperty
  a_gie: assert property (p_gie) else $error("take while disabled");
  property p_masked;
    @(posedge ref_clk) disable iff (sys_rst)
      can_take && win != 4'h0 |-> mask_q[win - 4'h1];
  endproperty
  a_masked: assert property (p_masked) else $error("masked taken");
  property p_ack;
    @(posedge ref_clk) disable iff (sys_rst)
      mode_q == ST_RUN && powerdown_enter |=> powerdown_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("no powerdown ack");
  property p_reset_mask;
    @(posedge ref_clk) sys_rst |=> mask_q == 11'h000 && sp_q == 4'h0;
  endproperty
  a_reset_mask: assert property (p_reset_mask) else $error("reset state");
  property p_pwd_vec;
    @(posedge ref_clk) disable iff (sys_rst)
      can_take && win == 4'h0 |=> int_vector == 14'h002c;
  endproperty
  a_pwd_vec: assert property (p_pwd_vec) else $error("bad pd vector");
  property p_stack;
    @(posedge ref_clk) disable iff (sys_rst) sp_q <= 4'hc;
  endproperty
  a_stack: assert property (p_stack) else $error("stack too deep");
  property p_wake;
    @(posedge ref_clk) disable iff (sys_rst)
      mode_q == ST_PWDN && !xtal_disabled ##1 mode_q == ST_WAKE |->
      ##[1:400] mode_q == ST_RUN;
  endproperty
  a_wake: assert property (p_wake) else $error("slow wake");

  // pending flags: set by the pin or force, cleared by take or clear
  property p_edge_set;
    @(posedge ref_clk) disable iff (sys_rst)
      fall[3] |=> edge_pend_q[irq_idle_pkg::SRC_EDGE];
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge lost");
  property p_edge_hold;
    @(posedge ref_clk) disable iff (sys_rst)
      edge_pend_q[5] && !fc_wr && !(can_take && win == 4'h6) |=>
      edge_pend_q[5];
  endproperty
  a_edge_hold: assert property (p_edge_hold) else $error("edge dropped");
  property p_force_pwd;
    @(posedge ref_clk) disable iff (sys_rst)
      fc_wr && fc_force[0] |=> pwd_pend_q;
  endproperty
  a_force_pwd: assert property (p_force_pwd) else $error("force lost");
  property p_clear_edge;
    @(posedge ref_clk) disable iff (sys_rst)
      fc_wr && fc_clear[6] && !fc_force[6] && !fall[3] |=> !edge_pend_q[5];
  endproperty
  a_clear_edge: assert property (p_clear_edge) else $error("clear lost");
  property p_pwd_first;
    @(posedge ref_clk) disable iff (sys_rst)
      pwd_pend_q && can_take |-> win == 4'h0;
  endproperty
  a_pwd_first: assert property (p_pwd_first) else $error("pd not first");
  property p_level_b;
    @(posedge ref_clk) disable iff (sys_rst)
      !sync_q[1] |-> pending[irq_idle_pkg::SRC_LVL_B];
  endproperty
  a_level_b: assert property (p_level_b) else $error("level missed");

  // modes: idle, slow idle, wake and power-down
  property p_idle_hold;
    @(posedge ref_clk) disable iff (sys_rst)
      mode_q == ST_IDLE |-> !can_take;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("take in idle");
  property p_idle_fast;
    @(posedge ref_clk) disable iff (sys_rst)
      mode_q == ST_IDLE && div_q == 8'h00 && win != 4'hf && gie_q |=>
      mode_q == ST_RUN;
  endproperty
  a_idle_fast: assert property (p_idle_fast) else $error("slow idle exit");
  property p_div_range;
    @(posedge ref_clk) disable iff (sys_rst)
      mode_q == ST_IDLE && div_q != 8'h00 |-> divcnt_q < div_q;
  endproperty
  a_div_range: assert property (p_div_range) else $error("divider wrap");
  property p_steal;
    @(posedge ref_clk) disable iff (sys_rst)
      mode_q != ST_PWDN |-> steal_grant == steal_req;
  endproperty
  a_steal: assert property (p_steal) else $error("steal refused");
  property p_pd_ack_rst;
    @(posedge ref_clk) sys_rst |=> !powerdown_ack;
  endproperty
  a_pd_ack_rst: assert property (p_pd_ack_rst) else $error("pd kept");
  property p_wake_clk;
    @(posedge ref_clk) disable iff (sys_rst)
      mode_q == ST_WAKE || mode_q == ST_PWDN |-> !core_clk_en;
  endproperty
  a_wake_clk: assert property (p_wake_clk) else $error("clock early");
  property p_ctx_run;
    @(posedge ref_clk) disable iff (sys_rst)
      mode_q == ST_RUN |-> !context_clear;
  endproperty
  a_ctx_run: assert property (p_ctx_run) else $error("stray clear");

  // stack and sequencing
  property p_seq;
    @(posedge ref_clk) disable iff (sys_rst)
      !ctrl_q[3] && active_q != 12'h000 |-> !can_take;
  endproperty
  a_seq: assert property (p_seq) else $error("nested while off");
  property p_pop;
    @(posedge ref_clk) disable iff (sys_rst)
      int_return && sp_q != 4'h0 && !can_take |=> sp_q == $past(sp_q) - 4'h1;
  endproperty
  a_pop: assert property (p_pop) else $error("pop lost");
  c_take: cover property (@(posedge ref_clk) int_take);
  c_slow: cover property (@(posedge ref_clk) idling && div_q != 8'h00);
  c_wake: cover property (@(posedge ref_clk) context_clear);
  c_idle: cover property (@(posedge ref_clk) idling ##1 !idling);
  c_pwdn: cover property (@(posedge ref_clk) powerdown_ack);
endmodule : irq_idle_ctrl

/* File: irq_pin_model.sv */
// model of the external interrupt and power-down pin sources
`timescale 1ns/10ps
module irq_pin_model (
  input wire logic ref_clk,
  input wire logic [6:0] drive_low,
  output logic [6:0] pins_n
);
  logic [6:0] low_q = 7'h00;
  logic [6:0] hold_q = 7'h00;
  // a line stays low two cycles at least, so the synchronizer catches it
  always_ff @(posedge ref_clk) begin
    low_q <= drive_low;
    hold_q <= low_q;
  end
  // released lines return to the pulled-up inactive level
  assign pins_n = ~(low_q | hold_q);
endmodule : irq_pin_model

/* File: interrupt_and_idle_control_tb.sv */
// self-checking bench for the interrupt and idle controller
`timescale 1ns/10ps
module interrupt_and_idle_control_tb;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] stb;
  logic alt_mode, div_en, xtal_off, ctx_bit;
  logic [10:0] periph_req, mask_wdata;
  logic [3:0] ctrl_wdata;
  logic [11:0] fc_force, fc_clear;
  logic [15:0] status_in, status_out;
  logic [1:0] div_sel;
  logic [2:0] steal_req, steal_grant;
  logic [6:0] drive_low, pins_n;
  logic int_take, stack_empty, core_clk_en, idling, powerdown_ack;
  logic [13:0] int_vector;
  logic [10:0] int_mask_reg, pending;
  logic [13:0] exp_q[$];
  logic [31:0] rnd = 32'hbc504992;
  int failures = 0;
  int num_checks = 0;
  int takes = 0;
  int want = 0;
  int en_cnt = 0;
  logic stack_overflow, context_clear;

  irq_pin_model irq_pin_model_i (.ref_clk(ref_clk), .drive_low(drive_low),
    .pins_n(pins_n));
  irq_idle_ctrl #(.WAKE_XTAL(20)) irq_idle_ctrl_i (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .ext_int_configurable_n(pins_n[0]),
    .ext_level_int_a_n(pins_n[1]), .ext_level_int_b_n(pins_n[2]),
    .ext_edge_int_n(pins_n[3]), .serial_b_alt_rx_int_n(pins_n[4]),
    .serial_b_alt_tx_int_n(pins_n[5]), .serial_b_alt_mode(alt_mode),
    .periph_req(periph_req), .powerdown_request_pin_n(pins_n[6]),
    .mask_wr(stb[5]), .mask_wdata(mask_wdata), .ctrl_wr(stb[7]),
    .ctrl_wdata(ctrl_wdata), .fc_wr(stb[6]), .fc_force(fc_force),
    .fc_clear(fc_clear), .global_int_enable_instr(stb[1]),
    .global_int_disable_instr(stb[0]), .int_return(stb[2]),
    .status_in(status_in), .idle_instr(stb[3]), .idle_div_sel(div_sel),
    .idle_div_en(div_en), .powerdown_enter(stb[4]), .xtal_disabled(xtal_off),
    .powerup_context_bit(ctx_bit), .steal_req(steal_req),
    .steal_grant(steal_grant), .int_take(int_take), .int_vector(int_vector),
    .status_out(status_out), .stack_empty(stack_empty),
    .stack_overflow(stack_overflow),
    .int_mask_reg(int_mask_reg), .pending(pending), .core_clk_en(core_clk_en),
    .idling(idling), .powerdown_ack(powerdown_ack),
    .context_clear(context_clear));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input string what, input logic [15:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc

  // strobes: 0 disable, 1 enable, 2 return, 3 idle, 4 powerdown, 5 mask,
  // 6 force/clear, 7 control
  task automatic strobe(input int k);
    stb[k] = 1'b1;
    cyc(1);
    stb[k] = 1'b0;
    cyc(1);
  endtask : strobe

  task automatic do_reset();
    sys_rst = 1'b1;
    cyc(3);
    sys_rst = 1'b0;
    cyc(4);
    check("int_mask_reg", 16'h0000, 16'(int_mask_reg));
    check("stack_empty", 16'h0001, 16'(stack_empty));
    check("stack_overflow", 16'h0000, 16'(stack_overflow));
    check("status_out", 16'h0000, status_out);
    check("powerdown_ack", 16'h0000, 16'(powerdown_ack));
  endtask : do_reset

  // pins (level and edge) stay low until the take; peripheral lines are one-cycle requests
  task automatic fire(input int i);
    if (i == 0 || i == 1 || i == 2 || i == 5) begin
      drive_low[i == 5 ? 3 : (i == 0 ? 0 : 3 - i)] = 1'b1;
    end else begin
      periph_req[i] = 1'b1;
      cyc(1);
      periph_req = '0;
    end
  endtask : fire

  task automatic wait_take();
    // counts takes in total, so a take inside the last task still counts
    want++;
    for (int k = 0; k < 40 && takes < want; k++) cyc(1);
    drive_low = '0;
    if (takes < want) begin
      failures++;
      $display("unexpected int_take: expected 1, seen 0");
    end
  endtask : wait_take

  // the pause lets released level pins settle before the return
  task automatic ret();
    cyc(6);
    strobe(2);
  endtask : ret

  task automatic push(input int i);
    exp_q.push_back(irq_idle_pkg::VEC_BASE + 14'(4 * i));
  endtask : push

  always @(negedge ref_clk) begin
    if (int_take === 1'b1) begin
      takes++;
      if (exp_q.size() == 0) begin
        failures++;
        $display("unexpected int_take: expected 0, seen 1");
      end else begin
        check("int_vector", 16'(exp_q.pop_front()), 16'(int_vector));
      end
    end
  end

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    #200000;
    failures++;
    give_verdict();
  end

  initial begin
    {stb, alt_mode, div_en, xtal_off, ctx_bit, div_sel, steal_req} = '0;
    {periph_req, ctrl_wdata, fc_force, fc_clear, status_in, drive_low} = '0;
    mask_wdata = 11'h7ff;
    do_reset();
    strobe(5);
    for (int i = 0; i < 11; i++) begin
      rnd = lfsr(rnd);
      status_in = rnd[15:0];
      push(i);
      fire(i);
      wait_take();
      check("stack_empty", 16'h0000, 16'(stack_empty));
      ret();
      check("stack_empty", 16'h0001, 16'(stack_empty));
      check("status_out", status_in, status_out);
    end
    push(3);
    push(9);
    periph_req = 11'h208;
    cyc(1);
    periph_req = '0;
    wait_take();
    ret();
    wait_take();
    ret();
    ctrl_wdata = 4'h8;
    strobe(7);
    push(9);
    push(3);
    fire(9);
    wait_take();
    fire(3);
    wait_take();
    ret();
    ret();
    mask_wdata = 11'h3ff;
    strobe(5);
    check("int_mask_reg", 16'h03ff, 16'(int_mask_reg));
    fire(10);
    cyc(10);
    check("pending", 16'h0001, 16'(pending[10]));
    exp_q.push_back(irq_idle_pkg::VEC_PWDN);
    fc_force = 12'h001;
    strobe(6);
    fc_force = '0;
    wait_take();
    ret();
    fc_clear = 12'h800;
    strobe(6);
    fc_clear = '0;
    check("pending", 16'h0000, 16'(pending[10]));
    mask_wdata = 11'h7ff;
    strobe(5);
    strobe(0);
    fire(6);
    cyc(10);
    push(6);
    strobe(1);
    wait_take();
    ret();
    strobe(3);
    cyc(3);
    check("idling", 16'h0001, 16'(idling));
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      steal_req = rnd[2:0];
      cyc(1);
      check("steal_grant", 16'(steal_req), 16'(steal_grant));
    end
    push(8);
    fire(8);
    wait_take();
    check("idling", 16'h0000, 16'(idling));
    ret();
    div_en = 1'b1;
    strobe(3);
    for (int k = 0; k < 32; k++) begin
      cyc(1);
      en_cnt += int'(core_clk_en);
    end
    check("core_clk_en", 16'h0002, 16'(en_cnt));
    push(8);
    fire(8);
    wait_take();
    check("idling", 16'h0000, 16'(idling));
    ret();
    div_en = 1'b0;
    exp_q.push_back(irq_idle_pkg::VEC_PWDN);
    drive_low[6] = 1'b1;
    cyc(2);
    drive_low[6] = 1'b0;
    wait_take();
    ret();
    alt_mode = 1'b1;
    ctrl_wdata = 4'h2;
    strobe(7);
    push(8);
    drive_low[4] = 1'b1;
    wait_take();
    ret();
    push(7);
    drive_low[5] = 1'b1;
    wait_take();
    ret();
    alt_mode = 1'b0;
    ctx_bit = 1'b1;
    xtal_off = 1'b1;
    strobe(4);
    cyc(5);
    check("powerdown_ack", 16'h0001, 16'(powerdown_ack));
    exp_q.push_back(irq_idle_pkg::VEC_PWDN);
    drive_low[6] = 1'b1;
    wait_take();
    check("context_clear", 16'h0001, 16'(context_clear));
    check("core_clk_en", 16'h0000, 16'(core_clk_en));
    cyc(25);
    check("core_clk_en", 16'h0001, 16'(core_clk_en));
    ret();
    strobe(4);
    cyc(3);
    do_reset();
    give_verdict();
  end
endmodule : interrupt_and_idle_control_tb
